// ### design/mmss_cfg.svh
// Constants for the module management serial and status block.
`ifndef MMSS_CFG_SVH
`define MMSS_CFG_SVH

// Timing: the laser must be dark within this time of the disable input.
`define MMSS_CLK_NS          10
`define MMSS_LASER_OFF_NS    10000
`define MMSS_LASER_OFF_CYC   (`MMSS_LASER_OFF_NS / `MMSS_CLK_NS)

// Two-wire device addresses, upper seven bits of the address byte.
`define MMSS_DEV_ID          7'h50
`define MMSS_DEV_DIAG        7'h51

// Register byte offsets on the AHB-Lite bus.
`define MMSS_REG_CTRL        8'h00
`define MMSS_REG_STATUS      8'h04
`define MMSS_REG_RAW_FIRST   8'h08
`define MMSS_REG_RAW_LAST    8'h18
`define MMSS_REG_MEM         8'h20

// Control register fields and reset value.
`define MMSS_CTRL_ID_PROT    0
`define MMSS_CTRL_DIAG_PROT  1
`define MMSS_CTRL_RST        2'h3

// Memory window register fields.
`define MMSS_MEM_GO          31
`define MMSS_MEM_DIAG        8

// Diagnostics map layout.
`define MMSS_NPARAM          5
`define MMSS_DIAG_READ_BASE  8'h60
`define MMSS_DIAG_READ_LAST  8'h69
`define MMSS_DIAG_ALARM      8'h70
`define MMSS_DIAG_WARN       8'h74
`define MMSS_DIAG_PROT_LIM   8'h80

// Flag vector positions of the bias and transmit power high alarms.
`define MMSS_FLAG_BIAS_HI    5
`define MMSS_FLAG_TXP_HI     3

`endif

// ### design/mmss_pkg.sv
// Types shared by the module management serial and status block.
package mmss_pkg;

    // Two-wire slave states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RX    = 3'h1,
        ST_ACK   = 3'h2,
        ST_TX    = 3'h3,
        ST_TXACK = 3'h4
    } mmss_state_t;

    // Meaning of the byte being received.
    typedef enum logic [1:0] {
        BY_DEV   = 2'h0,
        BY_WADDR = 2'h1,
        BY_WDATA = 2'h2
    } mmss_kind_t;

    // One byte write into either memory map.
    typedef struct packed {
        logic       we;
        logic       diag;
        logic [7:0] addr;
        logic [7:0] data;
    } mmss_wr_t;

    // Captured AHB address phase.
    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] addr;
    } mmss_aph_t;

endpackage

// ### design/mmss_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module mmss_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst,
    // Asynchronous level in, filtered level out.
    input  wire logic async,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    // Stage one is read by stage two only, to keep metastability contained.
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    // The filtered level ignores a single-cycle glitch between stages.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            level  <= RST_VAL;
        end else begin
            stage1 <= async;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule

// ### design/mmss_top.sv
// Transceiver management: two-wire memory maps, monitors and status pins.
// How it works
// - Answer two-wire address 1010000X with a 256-byte identification map.
// - Answer address 1010001X with the diagnostics map; identification map unchanged.
// - Sample data on serial clock rise; writes to protected areas are dropped.
// - Change returned data only after the serial clock falls.
// - Data line is two-way; detect start and stop conditions.
// - Maps are bytes; single and sequential access with address advance.
// - Diagnostics map holds continuously refreshed readings of five monitors.
// - Alarm and warning flags set when a reading leaves its range.
// - Readings are calibrated inside the module by default.
// - Signal lost output low on normal reception, high without signal.
// - Laser goes off within 10 us of the disable input rising.
// - Laser off while disable input high; on only while it is low.
// - Transmit fault high when bias or transmit power exceeds high alarm.
// - Presence line held low to show the module is inserted.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "mmss_cfg.svh"
module mmss_top (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite register slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Two-wire management bus; the data line is open drain.
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // Module status pins.
    input  wire logic        laserOffInput,
    input  wire logic        rxSignalDetect,
    output logic             signalLostFlag,
    output logic             txFault,
    output logic             laserOn,
    output logic             presentN
);
    import mmss_pkg::*;

    logic        sclS;
    logic        sdaS;
    logic        laserOffS;
    logic        rxDetS;
    logic [7:0]  idMem [256];
    logic [7:0]  diagMem [256];
    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic [31:0] raw [`MMSS_NPARAM];
    logic [31:0] next_raw [`MMSS_NPARAM];
    logic [8:0]  win;
    logic [8:0]  next_win;
    mmss_aph_t   aph;
    mmss_aph_t   next_aph;
    mmss_wr_t    ahbWr;
    mmss_wr_t    next_ahbWr;
    logic [31:0] next_hrdata;
    logic [15:0] reading [`MMSS_NPARAM];
    logic [15:0] next_reading [`MMSS_NPARAM];
    logic [9:0]  alarm;
    logic [9:0]  next_alarm;
    logic [9:0]  warn;
    logic [9:0]  next_warn;
    mmss_state_t state;
    mmss_state_t next_state;
    mmss_kind_t  kind;
    mmss_kind_t  next_kind;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [7:0]  ptr;
    logic [7:0]  next_ptr;
    logic        mapDiag;
    logic        next_mapDiag;
    logic        rdMode;
    logic        next_rdMode;
    logic        more;
    logic        next_more;
    logic        next_sdaOe;
    logic        sclPrev;
    logic        sdaPrev;
    mmss_wr_t    i2cWr;
    mmss_wr_t    next_i2cWr;

    // Calibration: raw count plus a software-loaded offset in the top half.
    function automatic logic [15:0] cal(input logic [31:0] r);
        cal = 16'(r[15:0] + r[31:16]);
    endfunction

    // Threshold k of parameter p: high alarm, low alarm, high and low warn.
    function automatic logic [15:0] thr(input int p, input int k);
        logic [7:0] a;
        a   = 8'(8 * p + 2 * k);
        thr = {diagMem[a], diagMem[8'(a + 8'h01)]};
    endfunction

    // Host writes to protected areas are dropped without error.
    function automatic logic prot(input logic diag, input logic [7:0] a);
        if (!diag) begin
            prot = ctrl[`MMSS_CTRL_ID_PROT];
        end else begin
            prot = ctrl[`MMSS_CTRL_DIAG_PROT] && (a < `MMSS_DIAG_PROT_LIM);
        end
    endfunction

    // Live monitor bytes override the stored diagnostics map.
    function automatic logic [7:0] rdByte(input logic diag,
                                          input logic [7:0] a);
        logic [2:0] i;
        i = 3'((a - `MMSS_DIAG_READ_BASE) >> 1);
        if (!diag) begin
            rdByte = idMem[a];
        end else if (a >= `MMSS_DIAG_READ_BASE &&
                     a <= `MMSS_DIAG_READ_LAST) begin
            rdByte = a[0] ? reading[i][7:0] : reading[i][15:8];
        end else if (a == `MMSS_DIAG_ALARM) begin
            rdByte = alarm[9:2];
        end else if (a == `MMSS_DIAG_ALARM + 8'h01) begin
            rdByte = {alarm[1:0], 6'h00};
        end else if (a == `MMSS_DIAG_WARN) begin
            rdByte = warn[9:2];
        end else if (a == `MMSS_DIAG_WARN + 8'h01) begin
            rdByte = {warn[1:0], 6'h00};
        end else begin
            rdByte = diagMem[a];
        end
    endfunction

    // The two-wire and status input pins pass the three-stage synchroniser.
    mmss_sync #(.RST_VAL(1'b1)) uSyncScl (
        .sys_clk (sys_clk), .rst (rst), .async (sclIn), .level (sclS));
    mmss_sync #(.RST_VAL(1'b1)) uSyncSda (
        .sys_clk (sys_clk), .rst (rst), .async (sdaIn), .level (sdaS));
    mmss_sync #(.RST_VAL(1'b1)) uSyncOff (
        .sys_clk (sys_clk), .rst (rst), .async (laserOffInput),
        .level (laserOffS));
    mmss_sync #(.RST_VAL(1'b0)) uSyncDet (
        .sys_clk (sys_clk), .rst (rst), .async (rxSignalDetect),
        .level (rxDetS));

    // Bus slave: zero wait states, write data used in the data phase.
    always_comb begin
        logic [2:0] ri;
        ri          = 3'((aph.addr - `MMSS_REG_RAW_FIRST) >> 2);
        next_ctrl   = ctrl;
        next_raw    = raw;
        next_win    = win;
        next_ahbWr  = '0;
        next_aph    = '0;
        next_hrdata = hrdata;
        if (aph.sel && aph.write) begin
            if (aph.addr == `MMSS_REG_CTRL) begin
                next_ctrl = hwdata[1:0];
            end else if (aph.addr == `MMSS_REG_MEM) begin
                next_win = hwdata[8:0];
                if (hwdata[`MMSS_MEM_GO]) begin
                    next_ahbWr = '{1'b1, hwdata[`MMSS_MEM_DIAG],
                                   hwdata[7:0], hwdata[23:16]};
                end
            end else if (aph.addr >= `MMSS_REG_RAW_FIRST &&
                         aph.addr <= `MMSS_REG_RAW_LAST) begin
                next_raw[ri] = hwdata;
            end
        end
        if (hsel && htrans[1] && hready) begin
            // Only aligned offsets in the low page decode; others read zero.
            next_aph = '{(haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0),
                         hwrite, haddr[7:0]};
            if (!hwrite) begin
                next_hrdata = 32'h0000_0000;
                if (next_aph.sel) begin
                    case (haddr[7:0])
                        `MMSS_REG_CTRL: next_hrdata = {30'h0, ctrl};
                        `MMSS_REG_STATUS: next_hrdata = {27'h0,
                            state != ST_IDLE, laserOffS, laserOn,
                            txFault, signalLostFlag};
                        `MMSS_REG_MEM: next_hrdata = {8'h00,
                            rdByte(win[8], win[7:0]), 7'h00, win};
                        default: begin
                            if (haddr[7:0] >= `MMSS_REG_RAW_FIRST &&
                                haddr[7:0] <= `MMSS_REG_RAW_LAST) begin
                                next_hrdata = raw[3'((haddr[7:0] -
                                    `MMSS_REG_RAW_FIRST) >> 2)];
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl      <= `MMSS_CTRL_RST;
            raw       <= '{default: 32'h0000_0000};
            win       <= 9'h000;
            aph       <= '0;
            ahbWr     <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            raw       <= next_raw;
            win       <= next_win;
            aph       <= next_aph;
            ahbWr     <= next_ahbWr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Both maps; factory loading over the bus wins a same-cycle collision.
    always_ff @(posedge sys_clk) begin
        if (ahbWr.we) begin
            if (ahbWr.diag) begin
                diagMem[ahbWr.addr] <= ahbWr.data;
            end else begin
                idMem[ahbWr.addr] <= ahbWr.data;
            end
        end else if (i2cWr.we) begin
            if (i2cWr.diag) begin
                diagMem[i2cWr.addr] <= i2cWr.data;
            end else begin
                idMem[i2cWr.addr] <= i2cWr.data;
            end
        end
    end

    // Monitors refresh every cycle; flags compare against stored limits.
    always_comb begin
        for (int p = 0; p < `MMSS_NPARAM; p++) begin
            next_reading[p] = cal(raw[p]);
            next_alarm[9 - 2 * p] = reading[p] > thr(p, 0);
            next_alarm[8 - 2 * p] = reading[p] < thr(p, 1);
            next_warn[9 - 2 * p]  = reading[p] > thr(p, 2);
            next_warn[8 - 2 * p]  = reading[p] < thr(p, 3);
        end
    end

    // Status pins are registered so they never glitch.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reading        <= '{default: 16'h0000};
            alarm          <= 10'h000;
            warn           <= 10'h000;
            signalLostFlag <= 1'b1;
            txFault        <= 1'b0;
            laserOn        <= 1'b0;
            presentN       <= 1'b0;
        end else begin
            reading        <= next_reading;
            alarm          <= next_alarm;
            warn           <= next_warn;
            signalLostFlag <= ~rxDetS;
            txFault        <= alarm[`MMSS_FLAG_BIAS_HI] |
                              alarm[`MMSS_FLAG_TXP_HI];
            // Sync plus one flop is five cycles, far inside the limit.
            laserOn        <= ~laserOffS;
            presentN       <= 1'b0;
        end
    end

    // Two-wire slave; the clock is only ever an input here.
    always_comb begin
        logic       sclRise;
        logic       sclFall;
        logic       ack;
        logic [7:0] txb;
        sclRise      = sclS & ~sclPrev;
        sclFall      = ~sclS & sclPrev;
        ack          = 1'b1;
        txb          = rdByte(mapDiag, ptr);
        next_state   = state;
        next_kind    = kind;
        next_cnt     = cnt;
        next_shift   = shift;
        next_ptr     = ptr;
        next_mapDiag = mapDiag;
        next_rdMode  = rdMode;
        next_more    = more;
        next_sdaOe   = sdaOe;
        next_i2cWr   = '0;
        if (sclS && sclPrev && ~sdaPrev && sdaS) begin
            next_state = ST_IDLE;
            next_sdaOe = 1'b0;
        end else if (sclS && sclPrev && sdaPrev && ~sdaS) begin
            next_state = ST_RX;
            next_kind  = BY_DEV;
            next_cnt   = 4'h0;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (sclRise && cnt != 4'h8) begin
                        next_shift = {shift[6:0], sdaS};
                        next_cnt   = cnt + 4'h1;
                    end else if (sclFall && cnt == 4'h8) begin
                        next_cnt = 4'h0;
                        case (kind)
                            BY_DEV: begin
                                if (shift[7:1] == `MMSS_DEV_ID ||
                                    shift[7:1] == `MMSS_DEV_DIAG) begin
                                    next_mapDiag = shift[7:1] ==
                                                   `MMSS_DEV_DIAG;
                                    next_rdMode  = shift[0];
                                end else begin
                                    ack = 1'b0;
                                end
                            end
                            BY_WADDR: next_ptr = shift;
                            default: begin
                                if (!prot(mapDiag, ptr)) begin
                                    next_i2cWr = '{1'b1, mapDiag, ptr,
                                                   shift};
                                end
                                next_ptr = ptr + 8'h01;
                            end
                        endcase
                        next_sdaOe = ack;
                        next_state = ack ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        if (kind == BY_DEV && rdMode) begin
                            next_shift = txb;
                            next_sdaOe = ~txb[7];
                            next_cnt   = 4'h0;
                            next_state = ST_TX;
                        end else begin
                            next_sdaOe = 1'b0;
                            next_state = ST_RX;
                            next_kind  = (kind == BY_DEV) ? BY_WADDR
                                                          : BY_WDATA;
                        end
                    end
                end
                ST_TX: begin
                    if (sclRise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (sclFall) begin
                        if (cnt == 4'h8) begin
                            next_sdaOe = 1'b0;
                            next_ptr   = ptr + 8'h01;
                            next_state = ST_TXACK;
                        end else begin
                            next_sdaOe = ~shift[3'(4'h7 - cnt)];
                        end
                    end
                end
                ST_TXACK: begin
                    if (sclRise) begin
                        next_more = ~sdaS;
                    end else if (sclFall) begin
                        if (more) begin
                            next_shift = txb;
                            next_sdaOe = ~txb[7];
                            next_cnt   = 4'h0;
                            next_state = ST_TX;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                default: next_sdaOe = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state   <= ST_IDLE;
            kind    <= BY_DEV;
            cnt     <= 4'h0;
            shift   <= 8'h00;
            ptr     <= 8'h00;
            mapDiag <= 1'b0;
            rdMode  <= 1'b0;
            more    <= 1'b0;
            sdaOe   <= 1'b0;
            sdaOut  <= 1'b0;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            i2cWr   <= '0;
        end else begin
            state   <= next_state;
            kind    <= next_kind;
            cnt     <= next_cnt;
            shift   <= next_shift;
            ptr     <= next_ptr;
            mapDiag <= next_mapDiag;
            rdMode  <= next_rdMode;
            more    <= next_more;
            sdaOe   <= next_sdaOe;
            sdaOut  <= 1'b0;
            sclPrev <= sclS;
            sdaPrev <= sdaS;
            i2cWr   <= next_i2cWr;
        end
    end
endmodule

// ### tb/mmss_checker.sv
// Pin-level assertions for the management serial and status block.
`timescale 1ns/1ns
module mmss_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Watched pins.
    input wire logic sclIn,
    input wire logic sdaOe,
    input wire logic sdaOut,
    input wire logic laserOffInput,
    input wire logic rxSignalDetect,
    input wire logic signalLostFlag,
    input wire logic laserOn,
    input wire logic presentN
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Status pins follow their inputs within eight cycles; the laser goes dark within 1000.
    property p_present; presentN == 1'b0; endproperty
    property p_losClr; $rose(rxSignalDetect) |-> ##[1:8] !signalLostFlag;
    endproperty
    property p_losSet; $fell(rxSignalDetect) |-> ##[1:8] signalLostFlag;
    endproperty
    property p_offTime; $rose(laserOffInput) |-> ##[1:1000] !laserOn;
    endproperty
    property p_offHold; laserOffInput [*8] |-> !laserOn; endproperty
    property p_onHold; (!laserOffInput) [*8] |-> laserOn; endproperty
    // Open drain: only the enable moves, and only while the clock is low.
    property p_sdaOut; sdaOut == 1'b0; endproperty
    property p_sdaEdge; $changed(sdaOe) |-> !sclIn; endproperty
    a_present: assert property (p_present) else $error("present high");
    a_losClr: assert property (p_losClr) else $error("lost stuck");
    a_losSet: assert property (p_losSet) else $error("lost missed");
    a_offTime: assert property (p_offTime) else $error("laser slow");
    a_offHold: assert property (p_offHold) else $error("laser lit");
    a_onHold: assert property (p_onHold) else $error("laser dark");
    a_sdaOut: assert property (p_sdaOut) else $error("data high");
    a_sdaEdge: assert property (p_sdaEdge) else $error("data moved");
    c_ack: cover property ($rose(sdaOe));
    c_lost: cover property ($rose(signalLostFlag));
    c_dark: cover property ($fell(laserOn));
endmodule
bind mmss_top mmss_checker chk_u (.sys_clk(sys_clk), .rst(rst),
    .sclIn(sclIn), .sdaOe(sdaOe), .sdaOut(sdaOut),
    .laserOffInput(laserOffInput), .rxSignalDetect(rxSignalDetect),
    .signalLostFlag(signalLostFlag), .laserOn(laserOn),
    .presentN(presentN));

// ### tb/mmss_host.sv
// Two-wire bus master standing in for the host board controller.
`timescale 1ns/1ns
module mmss_host (
    // Clock and data pull-down made by the host.
    output logic      scl,
    output logic      pull,
    // Resolved data line.
    input  wire logic sda
);
    // Idle: clock stands high and data is released between frames.
    initial {scl, pull} = 2'b10;
    // A 125 ns period leaves the slave six clock cycles in each phase.
    task automatic clk(input logic p, output logic b);
        #30 pull = p;
        #33 scl = 1'b1;
        #30 b = sda;
        #32 scl = 1'b0;
    endtask
    task automatic start();
        #30 pull = 1'b0;
        #33 scl = 1'b1;
        #30 pull = 1'b1;
        #32 scl = 1'b0;
    endtask
    task automatic stop();
        #30 pull = 1'b1;
        #33 scl = 1'b1;
        #30 pull = 1'b0;
        #32;
    endtask
    // Bytes go most significant bit first; ack low means accepted.
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) clk(!d[i], b);
        clk(1'b0, ack);
    endtask
    task automatic getByte(input logic last, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) clk(1'b0, d[i]);
        clk(!last, b);
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the management serial and status block.
`timescale 1ns/1ns
module tb;
    // Bench-driven inputs and observed outputs.
    logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, scl, pull;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sdaOut, sdaOe, laserOffInput, rxSignalDetect;
    logic        signalLostFlag, txFault, laserOn, presentN;
    wire         sda;
    int          fails, comparisons;
    // Open-drain data line with its pull-up.
    assign sda = !(sdaOe | pull);
    mmss_top dut_u (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .laserOffInput,
        .rxSignalDetect, .signalLostFlag, .txFault, .laserOn, .presentN);
    mmss_host host_u (.scl, .pull, .sda);
    // Free-running system clock.
    always #5 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the slave's ready; a hang ends the run.
    task automatic edgeReady();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            $display("FAIL %0t bus hang", $time);
            give_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        edgeReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edgeReady();
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rdChk(input logic [31:0] a, e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk(r, e);
    endtask
    function automatic logic pin(input int k);
        return k == 0 ? laserOn : k == 1 ? signalLostFlag : txFault;
    endfunction
    task automatic waitPin(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pin(k) !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        chk(32'(pin(k)), 32'(v));
        if (pin(k) !== v) give_verdict();
    endtask
    // Serial random read of two bytes, then a write of two bytes.
    task automatic rd2(input logic [7:0] dev, wa, e0, e1);
        logic       a0, a1, a2;
        logic [7:0] b0, b1;
        host_u.start();
        host_u.sendByte(dev, a0);
        host_u.sendByte(wa, a1);
        host_u.start();
        host_u.sendByte(dev | 8'h01, a2);
        host_u.getByte(1'b0, b0);
        host_u.getByte(1'b1, b1);
        host_u.stop();
        chk(32'({a0, a1, a2, b0, b1}), 32'({3'h0, e0, e1}));
    endtask
    task automatic wr2(input logic [7:0] dev, wa, d0, d1);
        logic a0, a1, a2, a3;
        host_u.start();
        host_u.sendByte(dev, a0);
        host_u.sendByte(wa, a1);
        host_u.sendByte(d0, a2);
        host_u.sendByte(d1, a3);
        host_u.stop();
        chk(32'({a0, a1, a2, a3}), 32'h0000_0000);
    endtask
    task automatic t_regs();
        rdChk(32'h0000_0000, 32'h0000_0003);
        wr(32'h0000_001C, 32'hFFFF_FFFF);
        rdChk(32'h0000_001C, 32'h0000_0000);
        chk(32'({hresp, presentN}), 32'h0000_0000);
        $display("regs done");
    endtask
    task automatic t_pins();
        laserOffInput <= 1'b0;
        waitPin(0, 1'b1, 20);
        laserOffInput <= 1'b1;
        waitPin(0, 1'b0, 1000);
        rxSignalDetect <= 1'b0;
        waitPin(1, 1'b1, 20);
        rxSignalDetect <= 1'b1;
        waitPin(1, 1'b0, 20);
        $display("pins done");
    endtask
    task automatic t_id();
        logic a;
        wr(32'h0000_0000, 32'h0000_0000);
        wr2(8'hA0, 8'hFF, 8'h11, 8'h22);
        rd2(8'hA0, 8'hFF, 8'h11, 8'h22);
        wr2(8'hA0, 8'h10, 8'h5A, 8'hA5);
        wr(32'h0000_0000, 32'h0000_0001);
        wr2(8'hA0, 8'h10, 8'h00, 8'h00);
        rd2(8'hA0, 8'h10, 8'h5A, 8'hA5);
        host_u.start();
        host_u.sendByte(8'hA4, a);
        host_u.stop();
        chk(32'(a), 32'h0000_0001);
        $display("id done");
    endtask
    // Limits open except bias high alarm 0x0100; monitors calibrated.
    task automatic t_diag();
        for (int i = 0; i < 40; i++) begin
            wr(32'h0000_0020, {8'h80, i == 16 ? 8'h01 :
                (i[1] || i == 17) ? 8'h00 : 8'hFF, 8'h01, 8'(i)});
        end
        for (int k = 0; k < 5; k++) begin
            wr(32'(8 + 4 * k), 32'h0000_0080);
        end
        wr(32'h0000_0010, 32'h0100_0100);
        waitPin(2, 1'b1, 10);
        rdChk(32'h0000_0004, 32'h0000_000A);
        rd2(8'hA2, 8'h64, 8'h02, 8'h00);
        rd2(8'hA2, 8'h70, 8'h08, 8'h00);
        rd2(8'hA0, 8'h10, 8'h5A, 8'hA5);
        wr(32'h0000_0000, 32'h0000_0003);
        wr2(8'hA2, 8'h10, 8'h00, 8'h00);
        wr(32'h0000_0010, 32'h0000_0050);
        waitPin(2, 1'b0, 10);
        rd2(8'hA2, 8'h64, 8'h00, 8'h50);
        $display("diag done");
    endtask
    // Reset, then each scenario in turn.
    initial begin
        {sys_clk, hsel, hwrite, haddr, hwdata, htrans, fails} = '0;
        {rst, laserOffInput, rxSignalDetect} = 3'h7;
        hsize = 3'h2;
        comparisons = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        t_regs();
        t_pins();
        t_id();
        t_diag();
        give_verdict();
    end
endmodule
